// [include/pcpwm_defines.svh]
// register offsets, strides and timing constants of the pulse counter unit
`ifndef PCPWM_DEFINES_SVH
`define PCPWM_DEFINES_SVH
`define PC_A_CFG0 8'h00
`define PC_A_CLR 8'h10
`define PC_A_CNT0 8'h20
`define PC_A_FCTL 8'h30
`define PC_A_F0N 8'h34
`define PC_A_F0K 8'h38
`define PC_A_F1N 8'h3C
`define PC_A_F1K 8'h40
`define PC_A_FSTAT 8'h44
`define PC_A_OMODE 8'h50
`define PC_A_OHOST 8'h54
`define PC_A_OPOL 8'h58
`define PC_A_OSTATE 8'h5C
`define PC_A_CMPHI0 8'h60
`define PC_A_CMPLO0 8'h70
`define PC_A_PWMMIN0 8'h80
`define PC_A_PWMMAX0 8'h84
`define PC_A_PWMTB 8'h90
`define PC_A_PWMCUST 8'h94
`define PC_STRIDE 8'h04
`define PC_PWM_STRIDE 8'h08
`define PC_CLK_NS 40
`define PC_MS_NS 1000000
`define PC_REF_MHZ 48
`define PC_SYS_MHZ 25
`define PC_BASE_10MS 16'h000A
`define PC_BASE_1S 16'h03E8
`define PC_BASE_10S 16'h2710
`define PC_CUST_RST 16'h0064
`endif

// [include/pcpwm_pkg.sv]
// types shared by the pulse counter unit
package pcpwm_pkg;
  typedef enum logic [1:0] {
    CM_OFF = 2'b00, CM_PROG = 2'b01, CM_UPDN = 2'b10, CM_QUAD = 2'b11
  } pcpwm_cmode_t;
  typedef enum logic [1:0] {
    OM_HOST = 2'b00, OM_PROC = 2'b01, OM_PWM = 2'b10, OM_RSV = 2'b11
  } pcpwm_omode_t;
  typedef enum logic {AS_IDLE = 1'b0, AS_ACK = 1'b1} pcpwm_apb_st_t;
  // counter channel configuration word, high bits first
  typedef struct packed {
    logic [2:0] clr_src;
    logic clr_en;
    logic [2:0] src_b;
    logic [2:0] src_a;
    pcpwm_cmode_t mode;
  } pcpwm_ccfg_t;
  // apb request bundle from the master
  typedef struct packed {
    logic [7:0] paddr;
    logic pwrite;
    logic psel;
    logic penable;
    logic [31:0] pwdata;
  } pcpwm_apb_req_t;
endpackage

// [rtl/pcpwm_top.sv]
// pulse counter, reciprocal frequency meter and status output unit with apb registers
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`include "pcpwm_defines.svh"
// How it works
// - result every 1 ms, 2 ms both on
// - time periods against 48 MHz reference count
// - two frequency channels, 1 Hz to 2 MHz
// - quadrature second input gives rotation direction
// - reference on edge, counts at interval end
// - progressive counter adds one on falling edge
// - every counter is signed 32 bit
// - clear by bus command or input
// - progressive only on inputs 1-4, 400 kHz
// - counters zero after power-up
// - up/down: falling edge, direction selects sign
// - at most four up/down counters
// - quadrature: both edges, equal levels count up
// - quadrature on any input, 400 kHz
// - host mode drives last written state
// - host reads back every output state
// - process mode asserts on threshold hit
// - process output has selectable polarity
// - pwm duty linear from min to max
// - pwm period from selectable time base
module pcpwm_top import pcpwm_pkg::*; #(
  parameter int MS_CYC = `PC_MS_NS / `PC_CLK_NS
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ce,
  // apb slave
  input wire pcpwm_apb_req_t apb_req,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q,
  // field terminals
  input wire logic [7:0] io_in,
  output logic [7:0] status_out_q
);
  // address match for arrayed registers
  function automatic logic hit(input logic [7:0] a, input logic [7:0] base,
                               input logic [7:0] stride, input int i);
    hit = (a == 8'(base + 8'(stride * 8'(i))));
  endfunction

  // period in ms for a time base selector
  function automatic logic [15:0] base_ms(input logic [1:0] sel, input logic [15:0] cust);
    case (sel)
      2'b00: base_ms = `PC_BASE_10MS;
      2'b01: base_ms = `PC_BASE_1S;
      2'b10: base_ms = `PC_BASE_10S;
      default: base_ms = cust;
    endcase
  endfunction

  logic [7:0] io_s1_q, io_s2_q, io_s3_q; // synchroniser chain plus history
  logic [7:0] rise, fall; // one-cycle edge pulses
  pcpwm_ccfg_t cfg_q [4]; // counter channel setup
  logic [31:0] cnt_q [4]; // signed counter values
  logic [3:0] clr_cmd; // bus clear pulse per counter
  logic [1:0] fen_q; // frequency channel enables
  logic [1:0] fnew_q, fdir_q; // fresh-result and direction flags
  logic [31:0] fn_q [2], fk_q [2]; // published edge count and reference span
  logic [31:0] edges_q [2], edge0_q [2]; // running edge count, count at last publish
  logic [31:0] lref_q [2], lref0_q [2]; // reference at last edge, at last publish
  logic [31:0] ref_q; // reference count
  logic [4:0] ph_q; // fractional phase of the reference
  logic [16:0] int_q; // interval timer
  logic int_tick; // end of measurement interval
  logic [15:0] omode_q; // two mode bits per output
  logic [7:0] host_q, pol_q; // host state and process polarity
  logic [31:0] hi_q [4], lo_q [4]; // process thresholds per counter
  logic [31:0] pmin_q [2], pmax_q [2]; // pwm scale ends
  logic [3:0] ptb_q; // pwm time base selectors
  logic [15:0] pcust_q; // custom pwm period in ms
  logic [15:0] ms_q; // millisecond prescaler
  logic ms_tick; // one-cycle millisecond pulse
  logic [15:0] ppos_q [2]; // position inside the pwm period
  logic [1:0] pwm_lvl; // pwm level per unit
  logic [7:0] out_d; // next status output levels
  pcpwm_apb_st_t st_q; // apb handshake state
  logic [31:0] rd_d; // read mux
  logic err_d; // unmapped address
  logic wr_en; // write commits this edge

  // two-flop synchroniser; edge logic compares the second stage with the third
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      io_s1_q <= 8'h00;
      io_s2_q <= 8'h00;
      io_s3_q <= 8'h00;
    end else if (ce) begin
      io_s1_q <= io_in;
      io_s2_q <= io_s1_q;
      io_s3_q <= io_s2_q;
    end
  end
  assign rise = io_s2_q & ~io_s3_q;
  assign fall = ~io_s2_q & io_s3_q;

  // apb handshake: setup, one wait cycle, then pready for one cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q <= AS_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (ce) begin
      case (st_q)
        AS_IDLE: begin
          if (apb_req.psel && apb_req.penable) begin
            st_q <= AS_ACK;
            pready_q <= 1'b1;
            pslverr_q <= err_d;
            prdata_q <= apb_req.pwrite ? 32'h0000_0000 : rd_d;
          end
        end
        AS_ACK: begin
          st_q <= AS_IDLE;
          pready_q <= 1'b0;
          pslverr_q <= 1'b0;
        end
        default: st_q <= AS_IDLE;
      endcase
    end
  end
  assign wr_en = (st_q == AS_ACK) && apb_req.psel && apb_req.penable &&
                 apb_req.pwrite && !pslverr_q;

  // read mux and address decode
  always_comb begin
    rd_d = 32'h0000_0000;
    err_d = 1'b0;
    case (apb_req.paddr)
      `PC_A_CLR: rd_d = 32'h0000_0000;
      `PC_A_FCTL: rd_d = {30'h0, fen_q};
      `PC_A_F0N: rd_d = fn_q[0];
      `PC_A_F0K: rd_d = fk_q[0];
      `PC_A_F1N: rd_d = fn_q[1];
      `PC_A_F1K: rd_d = fk_q[1];
      `PC_A_FSTAT: rd_d = {28'h0, fdir_q, fnew_q};
      `PC_A_OMODE: rd_d = {16'h0, omode_q};
      `PC_A_OHOST: rd_d = {24'h0, host_q};
      `PC_A_OPOL: rd_d = {24'h0, pol_q};
      `PC_A_OSTATE: rd_d = {24'h0, status_out_q};
      `PC_A_PWMTB: rd_d = {28'h0, ptb_q};
      `PC_A_PWMCUST: rd_d = {16'h0, pcust_q};
      default: begin
        err_d = 1'b1;
        for (int i = 0; i < 4; i++) begin
          if (hit(apb_req.paddr, `PC_A_CFG0, `PC_STRIDE, i)) begin
            rd_d = {20'h0, cfg_q[i]};
            err_d = 1'b0;
          end
          if (hit(apb_req.paddr, `PC_A_CNT0, `PC_STRIDE, i)) begin
            rd_d = cnt_q[i];
            err_d = 1'b0;
          end
          if (hit(apb_req.paddr, `PC_A_CMPHI0, `PC_STRIDE, i)) begin
            rd_d = hi_q[i];
            err_d = 1'b0;
          end
          if (hit(apb_req.paddr, `PC_A_CMPLO0, `PC_STRIDE, i)) begin
            rd_d = lo_q[i];
            err_d = 1'b0;
          end
        end
        for (int u = 0; u < 2; u++) begin
          if (hit(apb_req.paddr, `PC_A_PWMMIN0, `PC_PWM_STRIDE, u)) begin
            rd_d = pmin_q[u];
            err_d = 1'b0;
          end
          if (hit(apb_req.paddr, `PC_A_PWMMAX0, `PC_PWM_STRIDE, u)) begin
            rd_d = pmax_q[u];
            err_d = 1'b0;
          end
        end
      end
    endcase
  end

  // configuration registers written by software
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fen_q <= 2'b00;
      omode_q <= 16'h0000;
      host_q <= 8'h00;
      pol_q <= 8'h00;
      ptb_q <= 4'h0;
      pcust_q <= `PC_CUST_RST;
      for (int i = 0; i < 4; i++) begin
        cfg_q[i] <= '0;
        hi_q[i] <= 32'h7FFF_FFFF;
        lo_q[i] <= 32'h8000_0000;
      end
      for (int u = 0; u < 2; u++) begin
        pmin_q[u] <= 32'h0000_0000;
        pmax_q[u] <= 32'h0000_0064;
      end
    end else if (ce && wr_en) begin
      if (apb_req.paddr == `PC_A_FCTL) fen_q <= apb_req.pwdata[1:0];
      if (apb_req.paddr == `PC_A_OMODE) omode_q <= apb_req.pwdata[15:0];
      if (apb_req.paddr == `PC_A_OHOST) host_q <= apb_req.pwdata[7:0];
      if (apb_req.paddr == `PC_A_OPOL) pol_q <= apb_req.pwdata[7:0];
      if (apb_req.paddr == `PC_A_PWMTB) ptb_q <= apb_req.pwdata[3:0];
      if (apb_req.paddr == `PC_A_PWMCUST) pcust_q <= apb_req.pwdata[15:0];
      for (int i = 0; i < 4; i++) begin
        if (hit(apb_req.paddr, `PC_A_CFG0, `PC_STRIDE, i)) cfg_q[i] <= apb_req.pwdata[11:0];
        if (hit(apb_req.paddr, `PC_A_CMPHI0, `PC_STRIDE, i)) hi_q[i] <= apb_req.pwdata;
        if (hit(apb_req.paddr, `PC_A_CMPLO0, `PC_STRIDE, i)) lo_q[i] <= apb_req.pwdata;
      end
      for (int u = 0; u < 2; u++) begin
        if (hit(apb_req.paddr, `PC_A_PWMMIN0, `PC_PWM_STRIDE, u)) pmin_q[u] <= apb_req.pwdata;
        if (hit(apb_req.paddr, `PC_A_PWMMAX0, `PC_PWM_STRIDE, u)) pmax_q[u] <= apb_req.pwdata;
      end
    end
  end
  assign clr_cmd = (wr_en && apb_req.paddr == `PC_A_CLR) ? apb_req.pwdata[3:0] : 4'h0;

  // four counter channels; a channel is one up/down pair at most
  generate
    for (genvar c = 0; c < 4; c++) begin : g_cnt
      logic [2:0] sa, sb;
      logic ea_fall, ea_rise, lv_a, lv_b, clr;
      // progressive counting reaches only the first four terminals
      assign sa = (cfg_q[c].mode == CM_PROG) ? {1'b0, cfg_q[c].src_a[1:0]} :
                  cfg_q[c].src_a;
      assign sb = cfg_q[c].src_b;
      assign ea_fall = fall[sa];
      assign ea_rise = rise[sa];
      assign lv_a = io_s2_q[sa];
      assign lv_b = io_s2_q[sb];
      // clear from bus or from a level on the chosen input
      assign clr = clr_cmd[c] | (cfg_q[c].clr_en & io_s2_q[cfg_q[c].clr_src]);
      // sync reset stands in for power-up; adds wrap modulo 2^32
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          cnt_q[c] <= 32'h0000_0000;
        end else if (ce) begin
          if (clr) begin
            cnt_q[c] <= 32'h0000_0000;
          end else begin
            case (cfg_q[c].mode)
              CM_PROG: if (ea_fall) cnt_q[c] <= cnt_q[c] + 32'h1;
              CM_UPDN: begin
                if (ea_fall) cnt_q[c] <= lv_b ? cnt_q[c] - 32'h1 : cnt_q[c] + 32'h1;
              end
              CM_QUAD: begin
                if (ea_fall | ea_rise) begin
                  cnt_q[c] <= (lv_a == lv_b) ? cnt_q[c] + 32'h1 : cnt_q[c] - 32'h1;
                end
              end
              default: cnt_q[c] <= cnt_q[c];
            endcase
          end
        end
      end
    end
  endgenerate

  // reference count: 48 ticks per 25 clocks, one or two per clock
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ph_q <= 5'h00;
      ref_q <= 32'h0000_0000;
    end else if (ce) begin
      if (6'(ph_q) + 6'(`PC_REF_MHZ - `PC_SYS_MHZ) >= 6'(`PC_SYS_MHZ)) begin
        ph_q <= 5'(ph_q + 5'(`PC_REF_MHZ - 2 * `PC_SYS_MHZ));
        ref_q <= ref_q + 32'h2;
      end else begin
        ph_q <= 5'(ph_q + 5'(`PC_REF_MHZ - `PC_SYS_MHZ));
        ref_q <= ref_q + 32'h1;
      end
    end
  end

  // interval timer: 1 ms with one channel, 2 ms with both
  assign int_tick = (int_q == 17'((&fen_q) ? 2 * MS_CYC - 1 : MS_CYC - 1));
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      int_q <= 17'h0;
    end else if (ce) begin
      int_q <= (int_tick || fen_q == 2'b00) ? 17'h0 : int_q + 17'h1;
    end
  end

  // two reciprocal channels: terminal f measured, terminal f+4 for direction
  generate
    for (genvar f = 0; f < 2; f++) begin : g_frq
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          edges_q[f] <= 32'h0;
          edge0_q[f] <= 32'h0;
          lref_q[f] <= 32'h0;
          lref0_q[f] <= 32'h0;
          fn_q[f] <= 32'h0;
          fk_q[f] <= 32'h0;
          fdir_q[f] <= 1'b0;
          fnew_q[f] <= 1'b0;
        end else if (ce) begin
          if (fen_q[f] && rise[f]) begin
            edges_q[f] <= edges_q[f] + 32'h1;
            lref_q[f] <= ref_q;
            fdir_q[f] <= io_s2_q[f + 4];
          end
          // set beats software clear in the same cycle
          if (wr_en && apb_req.paddr == `PC_A_FSTAT && apb_req.pwdata[f]) fnew_q[f] <= 1'b0;
          if (fen_q[f] && int_tick) begin
            // slow signals with no edge publish n = 0; k spans back to the last earlier edge, so 1 Hz fits this window
            fn_q[f] <= edges_q[f] - edge0_q[f];
            fk_q[f] <= lref_q[f] - lref0_q[f];
            edge0_q[f] <= edges_q[f];
            lref0_q[f] <= lref_q[f];
            fnew_q[f] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // millisecond prescaler for the pwm time base
  assign ms_tick = (ms_q == 16'(MS_CYC - 1));
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ms_q <= 16'h0;
    end else if (ce) begin
      ms_q <= ms_tick ? 16'h0 : ms_q + 16'h1;
    end
  end

  // two pwm units on outputs 0 and 1, driven by counters 0 and 1
  generate
    for (genvar u = 0; u < 2; u++) begin : g_pwm
      logic [15:0] per;
      logic [32:0] span, off;
      logic [48:0] duty_fraction, pos_scaled;
      assign per = base_ms(ptb_q[2 * u +: 2], pcust_q);
      assign span = 33'($signed(pmax_q[u]) - $signed(pmin_q[u]));
      assign off = 33'($signed(cnt_q[u]) - $signed(pmin_q[u]));
      assign duty_fraction = 49'(off * per);
      assign pos_scaled = 49'(span * ppos_q[u]);
      // clamp outside the scale, linear inside
      assign pwm_lvl[u] = ($signed(cnt_q[u]) >= $signed(pmax_q[u])) ? 1'b1 :
                          ($signed(cnt_q[u]) <= $signed(pmin_q[u])) ? 1'b0 :
                          (pos_scaled < duty_fraction);
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          ppos_q[u] <= 16'h0;
        end else if (ce && ms_tick) begin
          ppos_q[u] <= (ppos_q[u] + 16'h1 >= per) ? 16'h0 : ppos_q[u] + 16'h1;
        end
      end
    end
  endgenerate

  // output select per terminal
  generate
    for (genvar j = 0; j < 8; j++) begin : g_out
      logic proc_hit;
      assign proc_hit = ($signed(cnt_q[j % 4]) > $signed(hi_q[j % 4])) ||
                        ($signed(cnt_q[j % 4]) < $signed(lo_q[j % 4]));
      always_comb begin
        case (pcpwm_omode_t'(omode_q[2 * j +: 2]))
          OM_HOST: out_d[j] = host_q[j];
          OM_PROC: out_d[j] = proc_hit ^ pol_q[j];
          OM_PWM: out_d[j] = (j < 2) ? pwm_lvl[j % 2] : 1'b0;
          default: out_d[j] = 1'b0;
        endcase
      end
    end
  endgenerate

  // registered status outputs
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      status_out_q <= 8'h00;
    end else if (ce) begin
      status_out_q <= out_d;
    end
  end

  // checks on counters 0 to 3, frequency channel 0 and output 2
  a_ref_rate: assert property (@(posedge sys_clk) disable iff (reset)
    ce |=> (ref_q - $past(ref_q)) inside {32'h1, 32'h2})
    else $error("reference count step wrong");
  a_freq_pub: assert property (@(posedge sys_clk) disable iff (reset)
    (ce && fen_q[0] && int_tick) |=> fnew_q[0] && fn_q[0] == $past(edges_q[0] - edge0_q[0]))
    else $error("frequency result not published");
  a_edge_cap: assert property (@(posedge sys_clk) disable iff (reset)
    (ce && fen_q[0] && rise[0]) |=> lref_q[0] == $past(ref_q))
    else $error("reference not captured on edge");
  a_dir_take: assert property (@(posedge sys_clk) disable iff (reset)
    (ce && fen_q[0] && rise[0]) |=> fdir_q[0] == $past(io_s2_q[4]))
    else $error("direction not taken");
  a_prog_step: assert property (@(posedge sys_clk) disable iff (reset)
    (ce && cfg_q[0].mode == CM_PROG && !g_cnt[0].clr) |=>
      cnt_q[0] == $past(cnt_q[0]) + ($past(g_cnt[0].ea_fall) ? 32'h1 : 32'h0))
    else $error("progressive count wrong");
  a_updn_step: assert property (@(posedge sys_clk) disable iff (reset)
    (ce && cfg_q[1].mode == CM_UPDN && !g_cnt[1].clr && g_cnt[1].ea_fall) |=>
      cnt_q[1] == $past(cnt_q[1]) + ($past(g_cnt[1].lv_b) ? 32'hFFFF_FFFF : 32'h1))
    else $error("up/down count wrong");
  a_quad_step: assert property (@(posedge sys_clk) disable iff (reset)
    (ce && cfg_q[2].mode == CM_QUAD && !g_cnt[2].clr && g_cnt[2].ea_rise &&
     g_cnt[2].lv_b) |=> cnt_q[2] == $past(cnt_q[2]) + 32'h1)
    else $error("quadrature count wrong");
  a_bus_clear: assert property (@(posedge sys_clk) disable iff (reset)
    (ce && clr_cmd[0]) |=> cnt_q[0] == 32'h0)
    else $error("counter not cleared");
  a_zero_boot: assert property (@(posedge sys_clk)
    $fell(reset) |-> cnt_q[0] == 32'h0 && cnt_q[3] == 32'h0)
    else $error("counter not zero after reset");
  a_host_out: assert property (@(posedge sys_clk) disable iff (reset)
    (ce && omode_q[5:4] == OM_HOST) |=> status_out_q[2] == $past(host_q[2]))
    else $error("host output mismatch");
  a_proc_pol: assert property (@(posedge sys_clk) disable iff (reset)
    (ce && omode_q[5:4] == OM_PROC) |=>
      status_out_q[2] == ($past(g_out[2].proc_hit) ^ $past(pol_q[2])))
    else $error("process output polarity wrong");
endmodule

// [tb/pcpwm_field_model.sv]
// field side model: sensors and encoders driving the eight input terminals
`timescale 1ns/100ps
module pcpwm_field_model #(
  parameter int HOLD = 32,
  parameter int HALF = 10
) (
  // clock and generator control
  input wire logic sys_clk,
  input wire logic gen_en,
  // terminals towards the unit
  output logic [7:0] io_in
);
  int gen_q; // half period counter of the frequency source
  initial begin
    io_in = 8'h00;
    gen_q = 0;
  end
  // set one terminal and hold it long enough for the counter rate limit
  task automatic drive(input int idx, input logic v);
    io_in[idx] <= v;
    repeat (HOLD) @(posedge sys_clk);
  endtask
  // one low-high-low pulse on a terminal
  task automatic pulse(input int idx);
    drive(idx, 1'b1);
    drive(idx, 1'b0);
  endtask
  // frequency source on terminal 0, 1.25 MHz stays inside the measured band
  always @(posedge sys_clk) begin
    if (gen_en) begin
      gen_q <= (gen_q == HALF - 1) ? 0 : gen_q + 1;
      if (gen_q == HALF - 1) begin
        io_in[0] <= ~io_in[0];
      end
    end
  end
endmodule

// [tb/pcpwm_top_tb.sv]
// self-checking bench for the pulse counter unit
`timescale 1ns/100ps
`include "pcpwm_defines.svh"
module pcpwm_top_tb import pcpwm_pkg::*;;
  localparam int MS = 100; // shortened millisecond, keeps the run small
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic gen_en = 1'b0;
  logic ce = 1'b1; // clock enable, dropped once to prove the freeze
  pcpwm_apb_req_t req = '0;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [7:0] io_in;
  logic [7:0] status_out_q;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  always #20 sys_clk = ~sys_clk;
  pcpwm_top #(.MS_CYC(MS)) DUT (.sys_clk(sys_clk), .reset(reset), .ce(ce), .apb_req(req),
    .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q), .io_in(io_in),
    .status_out_q(status_out_q));
  pcpwm_field_model u_field (.sys_clk(sys_clk), .gen_en(gen_en), .io_in(io_in));
  // verdict and end of run
  task automatic summarize();
    if (num_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // hang guard, far above the expected run length
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      summarize();
    end
  end
  // value comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    req.paddr <= a;
    req.pwrite <= w;
    req.pwdata <= d;
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    @(posedge sys_clk);
    req.penable <= 1'b1;
    // look between edges, where the registered answer has settled
    do begin
      @(negedge sys_clk);
    end while (pready_q !== 1'b1);
    r = prdata_q;
    e = pslverr_q;
    @(posedge sys_clk); // the edge that samples pready and takes it low again
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge sys_clk); // idle edge so the next request is never in the same step
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 32'h0, r, e);
    chk(r, exp);
  endtask
  // counter configuration word
  function automatic logic [31:0] cfg(input pcpwm_cmode_t m, input logic [2:0] a,
                                      input logic [2:0] b, input logic clr_on, input logic [2:0] cs);
    pcpwm_ccfg_t c;
    c = '{clr_src: cs, clr_en: clr_on, src_b: b, src_a: a, mode: m};
    return {20'h00000, c};
  endfunction
  // reset values and an unmapped place
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 4; i++) rd_chk(`PC_A_CNT0 + 8'(i * 4), 32'h0);
    rd_chk(`PC_A_CMPHI0, 32'h7FFFFFFF);
    apb(8'hFC, 1'b0, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
  endtask
  // falling edges only, signed wrap below zero, quadrature on both edges
  task automatic t_counters();
    wr(`PC_A_CFG0, cfg(CM_PROG, 3'h0, 3'h0, 1'b0, 3'h0));
    repeat (3) u_field.pulse(0);
    rd_chk(`PC_A_CNT0, 32'h3);
    wr(`PC_A_CFG0 + 8'h4, cfg(CM_UPDN, 3'h2, 3'h3, 1'b0, 3'h0));
    u_field.pulse(2);
    u_field.drive(3, 1'b1);
    repeat (2) u_field.pulse(2);
    rd_chk(`PC_A_CNT0 + 8'h4, 32'hFFFFFFFF);
    wr(`PC_A_CFG0 + 8'h8, cfg(CM_QUAD, 3'h6, 3'h7, 1'b0, 3'h0));
    u_field.drive(7, 1'b1);
    u_field.drive(6, 1'b1);
    u_field.drive(7, 1'b0);
    u_field.drive(6, 1'b0);
    rd_chk(`PC_A_CNT0 + 8'h8, 32'h2);
  endtask
  // clear by bus command and by a terminal
  task automatic t_clear();
    wr(`PC_A_CLR, 32'h1);
    rd_chk(`PC_A_CNT0, 32'h0);
    wr(`PC_A_CFG0 + 8'hC, cfg(CM_PROG, 3'h1, 3'h0, 1'b1, 3'h5));
    repeat (2) u_field.pulse(1);
    rd_chk(`PC_A_CNT0 + 8'hC, 32'h2);
    u_field.drive(5, 1'b1);
    rd_chk(`PC_A_CNT0 + 8'hC, 32'h0);
    u_field.drive(5, 1'b0);
    ce <= 1'b0;
    u_field.pulse(0); // a whole pulse while frozen leaves no edge behind
    ce <= 1'b1;
    rd_chk(`PC_A_CNT0, 32'h0);
  endtask
  // host, process and pwm driven outputs
  task automatic t_outputs();
    int hi;
    hi = 0;
    wr(`PC_A_OMODE, 32'h0);
    wr(`PC_A_OHOST, 32'hA5);
    @(negedge sys_clk);
    chk({24'h0, status_out_q}, 32'hA5);
    rd_chk(`PC_A_OSTATE, 32'hA5);
    wr(`PC_A_OHOST, 32'h0);
    wr(`PC_A_CMPLO0 + 8'h4, 32'h0);
    wr(`PC_A_OMODE, 32'h14); // outputs 1 and 2 watch counters 1 (below zero) and 2
    rd_chk(`PC_A_OSTATE, 32'h2);
    wr(`PC_A_OPOL, 32'h2);
    rd_chk(`PC_A_OSTATE, 32'h0);
    wr(`PC_A_PWMMAX0, 32'h2);
    wr(`PC_A_PWMTB, 32'h0);
    wr(`PC_A_OMODE, 32'h2);
    u_field.pulse(0); // counter 0 now halfway between min and max
    repeat (10 * MS) @(posedge sys_clk);
    repeat (10 * MS) begin
      @(negedge sys_clk);
      hi += (status_out_q[0] === 1'b1) ? 1 : 0;
    end
    chk(32'(hi), 32'(5 * MS));
  endtask
  // reciprocal frequency meter with direction input
  task automatic t_freq();
    u_field.drive(4, 1'b1);
    wr(`PC_A_FCTL, 32'h1);
    gen_en <= 1'b1;
    repeat (4 * MS) @(posedge sys_clk);
    rd_chk(`PC_A_F0N, 32'h5);
    rd_chk(`PC_A_F0K, 32'd192);
    rd_chk(`PC_A_FSTAT, 32'h5);
    wr(`PC_A_FCTL, 32'h3); // both channels on: interval doubles
    repeat (6 * MS) @(posedge sys_clk);
    rd_chk(`PC_A_F0N, 32'd10);
    rd_chk(`PC_A_F0K, 32'd384);
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_counters();
    t_clear();
    t_outputs();
    t_freq();
    summarize();
  end
endmodule
